// ==== core/sle_pkg.sv ====
// constants, types and state layout of the serial link exerciser
package sle_pkg;
   // register byte offsets
   localparam logic [7:0] REG_FORMAT  = 8'h00;
   localparam logic [7:0] REG_PATTERN = 8'h04;
   localparam logic [7:0] REG_SWITCH  = 8'h08;
   localparam logic [7:0] REG_REPLAY  = 8'h0C;
   localparam logic [7:0] REG_STATUS  = 8'h10;
   // format field positions
   localparam int F_BAUD = 0;   // 4 bits, rate index 0..10
   localparam int F_BITS = 4;   // 2 bits, 0..3 means 5..8 data bits
   localparam int F_STOP = 6;   // 1 bit, set for two stop bits
   localparam int F_PAR  = 7;   // 2 bits, 0 off, 1 even, 2 odd
   // pattern field positions
   localparam int F_PSEL = 0;   // 2 bits, stored pattern
   localparam int F_SRC  = 2;   // 1 bit, set for switch register
   localparam int F_LLEN = 3;   // 2 bits, line length select
   localparam int F_EOL  = 5;   // 2 bits, 0 none, 1 cr, 2 lf, 3 cr+lf
   localparam int F_DLY  = 7;   // 2 bits, end of line delay
   localparam int F_MODE = 9;   // 2 bits, 0 off, 1 single, 2 continuous
   // replay field positions
   localparam int F_REN  = 0;
   localparam int F_REV  = 1;
   localparam int F_SPD  = 2;   // 2 bits, 0 single step, 1..3 timed
   localparam int F_DBUF = 4;
   localparam int F_LOOP = 5;
   // status field positions
   localparam int F_LAST = 0;
   localparam int F_PERR = 8;
   localparam int F_BUSY = 9;
   localparam int F_ADDR = 16;
   // reset values
   localparam logic [8:0]  FORMAT_RST  = 9'h00A;  // 19200, 5 bits, 1 stop, no parity
   localparam logic [10:0] PATTERN_RST = 11'h000;
   localparam logic [7:0]  SWITCH_RST  = 8'h00;
   localparam logic [5:0]  REPLAY_RST  = 6'h00;
   // encodings
   localparam logic [1:0] PAR_OFF = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2;
   localparam logic [1:0] MODE_OFF = 2'h0, MODE_SINGLE = 2'h1, MODE_CONT = 2'h2;
   localparam logic [1:0] EOL_NONE = 2'h0, EOL_CR = 2'h1, EOL_LF = 2'h2, EOL_CRLF = 2'h3;
   localparam logic [1:0] SPD_SS = 2'h0;
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;
   localparam logic [7:0] ASCII_BASE = 8'h20;
   // timing figures in their own units
   localparam int CLK_HZ_DEF = 40_000_000;
   localparam int BAUD_NUM = 11;
   localparam int BAUD_BPS [BAUD_NUM] =
      '{110, 150, 300, 600, 1200, 1800, 2400, 3600, 4800, 9600, 19200};
   localparam int DLY_MS [4] = '{0, 50, 200, 800};
   localparam int REPLAY_HZ [4] = '{1, 4, 20, 100};  // entry 0 unused, single step
   localparam int LINE_LEN [4] = '{32, 64, 80, 132};
   // stored patterns
   localparam int PANGRAM_LEN = 71;
   localparam logic [8*PANGRAM_LEN-1:0] PANGRAM_TXT =
      "THE QUICK BROWN FOX JUMPED OVER THE LAZY DOGS BACK. 1 2 3 4 5 6 7 8 9 0";
   localparam int ASCII64_LEN = 64;
   localparam int ASCII96_LEN = 96;
   localparam int USER_LEN_DEF = 16;
   // state encodings
   typedef enum logic [5:0] {
      TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
      TX_PAR  = 6'h08, TX_STOP  = 6'h10, TX_DLY  = 6'h20
   } sle_tx_st_t;
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
      RX_PAR  = 5'h08, RX_STOP  = 5'h10
   } sle_rx_st_t;
   // state of the exerciser, all but the capture buffer and its read register
   typedef struct packed {
      logic [8:0]  fmt;
      logic [10:0] pat;
      logic [7:0]  sw;
      logic [5:0]  rep;
      sle_tx_st_t  tx_st;
      logic [25:0] tx_cnt;
      logic [3:0]  tx_bit;
      logic [7:0]  tx_sh;
      logic        tx_pbit;
      logic        tx_is_data;
      logic        txd;
      logic [1:0]  eol_ph;
      logic [7:0]  line_cnt;
      logic [6:0]  pat_addr;
      logic        single_pend;
      logic [1:0]  mode_prev;
      sle_rx_st_t  rx_st;
      logic [19:0] rx_cnt;
      logic [3:0]  rx_bit;
      logic [7:0]  rx_sh;
      logic        rx_s1;
      logic        rx_s2;
      logic [7:0]  last_rx;
      logic        perr;
      logic [9:0]  addr;
      logic [25:0] rep_cnt;
      logic        stp_s1;
      logic        stp_s2;
      logic        stp_prev;
      logic [7:0]  disp;
      logic        tx_busy;
      logic [31:0] rdata;
   } sle_state_t;
endpackage : sle_pkg

// ==== core/sle_exerciser.sv ====
// serial link exerciser: uart, pattern source, line control, capture buffer
//
// Operation
// - even or odd parity is appended on transmit and checked on receive
// - parity off: no parity bit, stop bits follow the last data bit
// - a received character failing the parity check raises parity error
// - switch mode sends the low switch bits, one per data bit; pattern mode ignores them
// - each received character is written to the 1024x8 buffer at its address
// - buffer address shown in binary, counts one per received character
// - display shows last received character or buffer entry, by select
// - reset zeroes pattern and buffer addresses and resets transmitter, receiver
// - replay steps the buffer address forward or reverse by direction select
// - replay steps at 4, 20, 100 per second or by single step
// - each step press in single step mode moves the address by one, except in a cycle that captures a character
// - eleven bit rates from 110 to 19200 bits per second
// - five to eight data bits for transmit and receive
// - one or two stop bits per transmitted character
// - four stored patterns: pangram, 64 set, 96 set, user pattern
// - source select picks stored pattern or switch register
// - characters per line counted in continuous mode, end of line at 32, 64, 80, 132
// - end of line inserts nothing, cr, lf, or cr then lf
// - after end of line characters wait 0, 50, 200 or 800 ms
// - continuous sends back to back; off sends nothing
// - each off to single change sends exactly one character
// - self test loops the transmit line into the receiver
`timescale 1ns/1ps
module sle_exerciser
   import sle_pkg::*;
#(
   parameter int CLK_HZ = CLK_HZ_DEF,
   parameter int USER_LEN = USER_LEN_DEF,
   parameter logic [8*USER_LEN_DEF-1:0] USER_PATTERN = {USER_LEN_DEF{8'h55}}
) (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // serial line and panel
   input  wire logic        rxd_i,
   input  wire logic        step_i,
   output logic             txd_o,
   output logic             tx_busy_o,
   // indicators
   output logic      [7:0]  disp_o,
   output logic      [9:0]  buf_addr_o,
   output logic             parity_err_o
);

   // refuse settings the counters cannot serve
   if (CLK_HZ < 2 * 19200 || CLK_HZ > 50_000_000) begin : g_chk_clk
      $error("sle_exerciser: CLK_HZ out of range");
   end
   if (USER_LEN < 1 || USER_LEN > USER_LEN_DEF) begin : g_chk_user
      $error("sle_exerciser: USER_LEN out of range");
   end

   sle_state_t s_r, s_nxt;
   logic [7:0] buf_mem [1024];
   logic [7:0] mem_q;
   logic       cap_we;
   logic [7:0] cap_d;

   // cycles per bit, rounded down so never over the bit time
   function automatic logic [19:0] bit_cyc(input logic [3:0] sel);
      int r;
      r = (sel < 4'(BAUD_NUM)) ? BAUD_BPS[sel] : BAUD_BPS[BAUD_NUM-1];
      return 20'(CLK_HZ / r);
   endfunction : bit_cyc
   // parity over the active data bits
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] bits,
                                    input logic [1:0] par);
      logic [7:0] m;
      m = d & (8'hFF >> (2'h3 - bits));
      return (^m) ^ (par == PAR_ODD);
   endfunction : par_bit

   function automatic logic [6:0] pat_len(input logic [1:0] sel);
      case (sel)
         2'h0:    return 7'(PANGRAM_LEN);
         2'h1:    return 7'(ASCII64_LEN);
         2'h2:    return 7'(ASCII96_LEN);
         default: return 7'(USER_LEN);
      endcase
   endfunction : pat_len

   // stored pattern contents
   function automatic logic [7:0] pat_char(input logic [1:0] sel, input logic [6:0] a);
      case (sel)
         2'h0:    return PANGRAM_TXT[8*(PANGRAM_LEN-1-int'(a)) +: 8];
         2'h1,
         2'h2:    return ASCII_BASE + 8'(a);
         default: return USER_PATTERN[8*int'(a) +: 8];
      endcase
   endfunction : pat_char

   // field views
   logic [3:0] f_baud;
   logic [1:0] f_bits, f_par, f_psel, f_llen, f_eol, f_dly, f_mode, f_spd;
   logic       f_stop2, f_src, f_ren, f_rev, f_dbuf, f_loop;
   logic [19:0] bit_c;
   logic [3:0]  nbits;
   logic        rx_line, rx_done, step_evt, rep_tick;
   assign f_baud  = s_r.fmt[F_BAUD +: 4];
   assign f_bits  = s_r.fmt[F_BITS +: 2];
   assign f_stop2 = s_r.fmt[F_STOP];
   assign f_par   = s_r.fmt[F_PAR +: 2];
   assign f_psel  = s_r.pat[F_PSEL +: 2];
   assign f_src   = s_r.pat[F_SRC];
   assign f_llen  = s_r.pat[F_LLEN +: 2];
   assign f_eol   = s_r.pat[F_EOL +: 2];
   assign f_dly   = s_r.pat[F_DLY +: 2];
   assign f_mode  = s_r.pat[F_MODE +: 2];
   assign f_ren   = s_r.rep[F_REN];
   assign f_rev   = s_r.rep[F_REV];
   assign f_spd   = s_r.rep[F_SPD +: 2];
   assign f_dbuf  = s_r.rep[F_DBUF];
   assign f_loop  = s_r.rep[F_LOOP];
   assign bit_c   = bit_cyc(f_baud);
   assign nbits   = 4'd5 + 4'(f_bits);
   // loopback takes the registered line, already in this domain
   assign rx_line = f_loop ? s_r.txd : s_r.rx_s2;
   assign rx_done = (s_r.rx_st == RX_STOP) && (s_r.rx_cnt == 20'h0);
   assign step_evt = s_r.stp_s2 && !s_r.stp_prev;
   assign rep_tick = (f_spd != SPD_SS) && (s_r.rep_cnt == 26'h0);

   // next state
   always_comb begin
      s_nxt = s_r;
      cap_we = 1'b0;
      cap_d = s_r.rx_sh;
      // synchronisers
      s_nxt.rx_s1 = rxd_i;
      s_nxt.rx_s2 = s_r.rx_s1;
      s_nxt.stp_s1 = step_i;
      s_nxt.stp_s2 = s_r.stp_s1;
      s_nxt.stp_prev = s_r.stp_s2;
      // register writes
      if (wr_i) begin
         unique case (addr_i)
            REG_FORMAT:  s_nxt.fmt = wdata_i[8:0];
            REG_PATTERN: s_nxt.pat = wdata_i[10:0];
            REG_SWITCH:  s_nxt.sw  = wdata_i[7:0];
            REG_REPLAY:  s_nxt.rep = wdata_i[5:0];
            default: ;
         endcase
      end
      // register reads, data valid only in the following cycle
      s_nxt.rdata = 32'h0;
      if (rd_i) begin
         unique case (addr_i)
            REG_FORMAT:  s_nxt.rdata = {23'h0, s_r.fmt};
            REG_PATTERN: s_nxt.rdata = {21'h0, s_r.pat};
            REG_SWITCH:  s_nxt.rdata = {24'h0, s_r.sw};
            REG_REPLAY:  s_nxt.rdata = {26'h0, s_r.rep};
            REG_STATUS: begin
               s_nxt.rdata[F_LAST +: 8]  = s_r.last_rx;
               s_nxt.rdata[F_PERR]       = s_r.perr;
               s_nxt.rdata[F_BUSY]       = (s_r.tx_st != TX_IDLE);
               s_nxt.rdata[F_ADDR +: 10] = s_r.addr;
            end
            default: s_nxt.rdata = 32'h0;
         endcase
      end
      // a single request is armed only by the off to single change
      s_nxt.mode_prev = f_mode;
      if (f_mode == MODE_SINGLE && s_r.mode_prev == MODE_OFF) begin
         s_nxt.single_pend = 1'b1;
      end else if (f_mode == MODE_OFF) begin
         s_nxt.single_pend = 1'b0;
      end
      // transmitter
      if (s_r.tx_cnt != 26'h0) begin
         s_nxt.tx_cnt = s_r.tx_cnt - 26'h1;
      end
      unique case (s_r.tx_st)
         TX_IDLE: begin
            s_nxt.txd = 1'b1;
            if (f_mode == MODE_CONT && s_r.eol_ph != 2'h0) begin
               s_nxt.tx_sh = (s_r.eol_ph == 2'h1) ? CHAR_CR : CHAR_LF;
               s_nxt.tx_is_data = 1'b0;
               s_nxt.tx_st = TX_START;
            end else if (f_mode == MODE_CONT ||
                         (f_mode == MODE_SINGLE && s_r.single_pend)) begin
               s_nxt.single_pend = 1'b0;
               s_nxt.tx_is_data = 1'b1;
               s_nxt.tx_st = TX_START;
               if (f_src) begin
                  s_nxt.tx_sh = s_r.sw;
               end else begin
                  s_nxt.tx_sh = pat_char(f_psel, s_r.pat_addr);
                  s_nxt.pat_addr = (s_r.pat_addr >= pat_len(f_psel) - 7'h1) ?
                                   7'h0 : s_r.pat_addr + 7'h1;
               end
            end
            if (s_nxt.tx_st == TX_START) begin
               s_nxt.tx_pbit = par_bit(s_nxt.tx_sh, f_bits, f_par);
               s_nxt.txd = 1'b0;
               s_nxt.tx_cnt = 26'(bit_c - 20'h1);
               s_nxt.tx_bit = 4'h0;
            end
         end
         TX_START, TX_DATA, TX_PAR, TX_STOP: begin
            if (s_r.tx_cnt == 26'h0) begin
               s_nxt.tx_cnt = 26'(bit_c - 20'h1);
               s_nxt.tx_bit = s_r.tx_bit + 4'h1;
               if (s_r.tx_st == TX_START ||
                   (s_r.tx_st == TX_DATA && s_r.tx_bit != nbits)) begin
                  s_nxt.txd = s_r.tx_sh[0];
                  s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
                  s_nxt.tx_st = TX_DATA;
                  if (s_r.tx_st == TX_START) begin
                     s_nxt.tx_bit = 4'h1;
                  end
               end else if (s_r.tx_st == TX_DATA && f_par != PAR_OFF) begin
                  s_nxt.txd = s_r.tx_pbit;
                  s_nxt.tx_st = TX_PAR;
               end else if (s_r.tx_st != TX_STOP) begin
                  s_nxt.txd = 1'b1;
                  s_nxt.tx_bit = 4'h1;
                  s_nxt.tx_st = TX_STOP;
               end else if (f_stop2 && s_r.tx_bit == 4'h1) begin
                  s_nxt.txd = 1'b1;
               end else begin
                  // character done: line counting and end of line
                  s_nxt.tx_st = TX_IDLE;
                  s_nxt.tx_cnt = 26'h0;
                  if (s_r.tx_is_data && f_mode == MODE_CONT) begin
                     if (s_r.line_cnt + 8'h1 == 8'(LINE_LEN[f_llen])) begin
                        s_nxt.line_cnt = 8'h0;
                        s_nxt.eol_ph = (f_eol == EOL_NONE) ? 2'h0 :
                                       (f_eol == EOL_LF) ? 2'h2 : 2'h1;
                     end else begin
                        s_nxt.line_cnt = s_r.line_cnt + 8'h1;
                     end
                  end else if (!s_r.tx_is_data) begin
                     if (s_r.eol_ph == 2'h1 && f_eol == EOL_CRLF) begin
                        s_nxt.eol_ph = 2'h2;
                     end else begin
                        s_nxt.eol_ph = 2'h0;
                        s_nxt.tx_cnt = 26'(DLY_MS[f_dly] * (CLK_HZ / 1000));
                        if (f_dly != 2'h0) begin
                           s_nxt.tx_st = TX_DLY;
                        end
                     end
                  end
               end
            end
         end
         TX_DLY: begin
            if (s_r.tx_cnt == 26'h0) begin
               s_nxt.tx_st = TX_IDLE;
            end
         end
         default: s_nxt.tx_st = TX_IDLE;
      endcase
      s_nxt.tx_busy = (s_nxt.tx_st != TX_IDLE);
      // receiver, start bit checked at its middle
      if (s_r.rx_cnt != 20'h0) begin
         s_nxt.rx_cnt = s_r.rx_cnt - 20'h1;
      end
      unique case (s_r.rx_st)
         RX_IDLE: begin
            if (!rx_line) begin
               s_nxt.rx_st = RX_START;
               s_nxt.rx_cnt = bit_c >> 1;
            end
         end
         RX_START: begin
            if (s_r.rx_cnt == 20'h0) begin
               s_nxt.rx_st = rx_line ? RX_IDLE : RX_DATA;
               s_nxt.rx_cnt = bit_c - 20'h1;
               s_nxt.rx_bit = 4'h0;
            end
         end
         RX_DATA: begin
            if (s_r.rx_cnt == 20'h0) begin
               s_nxt.rx_cnt = bit_c - 20'h1;
               s_nxt.rx_sh = {rx_line, s_r.rx_sh[7:1]};
               s_nxt.rx_bit = s_r.rx_bit + 4'h1;
               if (s_r.rx_bit + 4'h1 == nbits) begin
                  // align the short character to bit 0
                  s_nxt.rx_sh = {rx_line, s_r.rx_sh[7:1]} >> (2'h3 - f_bits);
                  s_nxt.rx_st = (f_par != PAR_OFF) ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR: begin
            if (s_r.rx_cnt == 20'h0) begin
               s_nxt.rx_cnt = bit_c - 20'h1;
               s_nxt.perr = (rx_line != par_bit(s_r.rx_sh, f_bits, f_par));
               s_nxt.rx_st = RX_STOP;
            end
         end
         RX_STOP: begin
            if (rx_done) begin
               s_nxt.rx_st = RX_IDLE;
               s_nxt.last_rx = s_r.rx_sh;
               if (f_par == PAR_OFF) begin
                  s_nxt.perr = 1'b0;
               end
               cap_we = 1'b1;
            end
         end
         default: s_nxt.rx_st = RX_IDLE;
      endcase
      // buffer address: capture outranks replay stepping
      if (f_ren && f_spd != SPD_SS) begin
         s_nxt.rep_cnt = rep_tick ? 26'(CLK_HZ / REPLAY_HZ[f_spd] - 1) :
                                    s_r.rep_cnt - 26'h1;
      end
      if (cap_we) begin
         s_nxt.addr = s_r.addr + 10'h1;
      end else if (f_ren && ((f_spd == SPD_SS) ? step_evt : rep_tick)) begin
         s_nxt.addr = f_rev ? s_r.addr - 10'h1 : s_r.addr + 10'h1;
      end
      // display source
      s_nxt.disp = f_dbuf ? mem_q : s_r.last_rx;
   end

   // state register
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.fmt <= FORMAT_RST;
         s_r.pat <= PATTERN_RST;
         s_r.sw <= SWITCH_RST;
         s_r.rep <= REPLAY_RST;
         s_r.tx_st <= TX_IDLE;
         s_r.rx_st <= RX_IDLE;
         s_r.txd <= 1'b1;
         s_r.rx_s1 <= 1'b1;
         s_r.rx_s2 <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // capture buffer; display of a new buffer address lags by two cycles
   always_ff @(posedge clock_i) begin
      if (cap_we) begin
         buf_mem[s_r.addr] <= cap_d;
      end
      mem_q <= buf_mem[s_r.addr];
   end

   // outputs straight from the state register
   assign rdata_o      = s_r.rdata;
   assign txd_o        = s_r.txd;
   assign tx_busy_o    = s_r.tx_busy;
   assign disp_o       = s_r.disp;
   assign buf_addr_o   = s_r.addr;
   assign parity_err_o = s_r.perr;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   a_reset_zero: assert property (@(posedge clock_i) disable iff (1'b0)
      rst_i |=> (buf_addr_o == 10'h0 && s_r.pat_addr == 7'h0 && txd_o))
      else $error("reset did not clear addresses");
   a_off_silent: assert property (
      (f_mode == MODE_OFF && s_r.tx_st == TX_IDLE && !wr_i) |=> s_r.tx_st == TX_IDLE)
      else $error("transmit started while off");
   a_cap_count: assert property (
      rx_done |=> buf_addr_o == $past(buf_addr_o) + 10'h1)
      else $error("capture did not advance address");
   a_step_dir: assert property (
      (step_evt && f_ren && f_spd == SPD_SS && !rx_done && !wr_i) |=>
      buf_addr_o == (f_rev ? $past(buf_addr_o) - 10'h1 : $past(buf_addr_o) + 10'h1))
      else $error("single step moved address wrongly");
   a_parity_flag: assert property (
      (s_r.rx_st == RX_PAR && s_r.rx_cnt == 20'h0 &&
       rx_line != par_bit(s_r.rx_sh, f_bits, f_par)) |=> parity_err_o)
      else $error("parity failure not flagged");
   a_no_par_bit: assert property (
      (s_r.tx_st == TX_DATA && s_r.tx_cnt == 26'h0 && s_r.tx_bit == nbits &&
       f_par == PAR_OFF) |=> (s_r.tx_st == TX_STOP && txd_o))
      else $error("stop bit did not follow data");
   a_start_low: assert property (
      s_r.tx_st == TX_START |-> !txd_o)
      else $error("start bit not low");
   a_wrap_addr: assert property (
      (rx_done && buf_addr_o == 10'h3FF) |=> buf_addr_o == 10'h0)
      else $error("buffer address did not wrap");
   a_single_one: assert property (
      (s_r.tx_st == TX_IDLE && f_mode == MODE_SINGLE && !s_r.single_pend && !wr_i) |=>
      s_r.tx_st == TX_IDLE)
      else $error("single mode sent an extra character");
   a_eol_delay: assert property (
      (s_r.tx_st == TX_DLY && s_r.tx_cnt != 26'h0 && !wr_i) |=> s_r.tx_st == TX_DLY)
      else $error("delay ended early");

endmodule : sle_exerciser

// ==== dv/sle_term_model.sv ====
// terminal model: decodes the transmit line, sends characters on the receive line
`timescale 1ns/1ps
module sle_term_model (
   // clock and line settings
   input  wire logic       clock_i,
   input  wire logic [3:0] nbits_i,
   input  wire logic [7:0] bit_cyc_i,
   input  wire logic       par_on_i,
   // serial lines
   input  wire logic       txd_i,
   output logic            rxd_o,
   // decoded character, with the bit that follows its data on top
   output logic      [8:0] got_o,
   output logic            got_v_o
);
   logic [7:0] d;
   initial begin
      rxd_o = 1'b1;
      got_v_o = 1'b0;
      got_o = '0;
   end
   // bit centres found by counting clocks from the start edge
   always begin
      @(negedge txd_i);
      d = '0;
      repeat (bit_cyc_i / 2) @(posedge clock_i);
      for (int i = 0; i < nbits_i; i++) begin
         repeat (bit_cyc_i) @(posedge clock_i);
         d[i] = txd_i;
      end
      repeat (bit_cyc_i) @(posedge clock_i);
      got_o <= {txd_i, d};
      if (par_on_i) repeat (bit_cyc_i) @(posedge clock_i);
      got_v_o <= 1'b1;
      @(posedge clock_i);
      got_v_o <= 1'b0;
   end
   // one frame on the receive line; the line rests at mark between frames
   task automatic send(input logic [7:0] c, input logic [3:0] n, input logic pb,
                       input logic [7:0] bc);
      @(posedge clock_i);
      rxd_o <= 1'b0;
      repeat (bc) @(posedge clock_i);
      for (int i = 0; i < n; i++) begin
         rxd_o <= c[i];
         repeat (bc) @(posedge clock_i);
      end
      rxd_o <= pb;
      repeat (bc) @(posedge clock_i);
      rxd_o <= 1'b1;
      repeat (2 * bc) @(posedge clock_i);
   endtask : send
endmodule : sle_term_model

// ==== dv/serial_link_exerciser_tb_top.sv ====
// self-checking bench for the serial link exerciser
`timescale 1ns/1ps
module serial_link_exerciser_tb_top
   import sle_pkg::*;
;
   localparam int CLK = 192000;  // 10 clocks per bit at 19200
   localparam int BC = CLK / 19200;
   logic        clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, step_i = 1'b0;
   logic        rd_d = 1'b0, pon = 1'b1, txd_o, tx_busy_o, parity_err_o, rxd, gv;
   logic [7:0]  addr_i = '0, c, disp_o;
   logic [31:0] wdata_i = '0, rdata_o;
   logic [9:0]  buf_addr_o;
   logic [8:0]  got;
   logic [3:0]  nb = 4'd8;
   logic [31:0] rq[$];
   logic [8:0]  eq[$];
   int          errors = 0, cmp_count = 0, cyc = 0;

   sle_exerciser #(.CLK_HZ(CLK)) i_sle_exerciser (.clock_i(clock_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .rxd_i(rxd), .step_i(step_i), .txd_o(txd_o), .tx_busy_o(tx_busy_o),
      .disp_o(disp_o), .buf_addr_o(buf_addr_o), .parity_err_o(parity_err_o));
   sle_term_model i_sle_term_model (.clock_i(clock_i), .nbits_i(nb), .bit_cyc_i(BC[7:0]),
      .par_on_i(pon), .txd_i(txd_o), .rxd_o(rxd), .got_o(got), .got_v_o(gv));

   initial forever #12.5 clock_i = ~clock_i;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
   endtask : rd
   // bounded wait until every noted character has been seen
   task automatic wait_q();
      for (int k = 0; k < 6000 && eq.size() != 0; k++) @(posedge clock_i);
   endtask : wait_q
   task automatic wrap_up();
      if (eq.size() != 0) errors++;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // watcher: read data stands only in the cycle after the strobe
   always @(posedge clock_i) begin
      rd_d <= rd_i;
      if (rd_d) chk("rdata", rdata_o, rq.pop_front());
      if (gv) chk("char", {23'h0, got}, {23'h0, eq.pop_front()});
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(32'h55fd));
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(REG_FORMAT, {23'h0, FORMAT_RST});
      rd(REG_STATUS, 32'h0);
      rd(8'h14, 32'h0);
      $display("test reset done");
      // switch characters, single shots, looped back, even then odd parity
      wr(REG_REPLAY, 32'h20);
      for (int i = 0; i < 2; i++) begin
         c = 8'($urandom);
         wr(REG_FORMAT, 32'h3A | ((i + 1) << 7));
         wr(REG_SWITCH, {24'h0, c});
         eq.push_back({(i == 0) ? ^c : ~^c, c});
         wr(REG_PATTERN, 32'h204);
         repeat (3) @(posedge clock_i);
         chk("busy", tx_busy_o, 1'b1);
         wait_q();
         wr(REG_PATTERN, 32'h4);
         repeat (10) @(posedge clock_i);
         chk("addr", buf_addr_o, i + 1);
         chk("disp", disp_o, c);
         chk("busy", tx_busy_o, 1'b0);
         chk("perr", parity_err_o, 1'b0);
      end
      $display("test single done");
      // 64 set, 32 per line, cr lf, 7 bits, two stop bits, no parity
      nb <= 4'd7;
      pon <= 1'b0;
      wr(REG_FORMAT, 32'h6A);
      for (int k = 0; k < 36; k++)
         eq.push_back({1'b1, k < 32 ? 8'(ASCII_BASE + k) : k == 32 ? CHAR_CR :
                      k == 33 ? CHAR_LF : 8'(8'h1E + k)});
      wr(REG_PATTERN, 32'h461);
      wait_q();
      wr(REG_PATTERN, 32'h60);
      repeat (200) @(posedge clock_i);
      chk("addr", buf_addr_o, 38);
      $display("test continuous done");
      // terminal sends odd parity characters, the first one wrong
      wr(REG_REPLAY, 32'h0);
      wr(REG_FORMAT, 32'h13A);
      for (int i = 0; i < 2; i++) begin
         c = 8'($urandom);
         i_sle_term_model.send(c, 4'd8, (i == 0) ? ^c : ~^c, BC[7:0]);
         chk("perr", parity_err_o, i == 0);
         chk("disp", disp_o, c);
      end
      $display("test parity done");
      // three single steps backwards, buffer on the display
      wr(REG_REPLAY, 32'h13);
      for (int i = 0; i < 3; i++) begin
         step_i <= 1'b1;
         repeat (8) @(posedge clock_i);
         step_i <= 1'b0;
         repeat (8) @(posedge clock_i);
      end
      chk("addr", buf_addr_o, 37);
      chk("disp", disp_o, 8'h41);
      $display("test replay done");
      // timed replay forward at the fastest rate, one step per CLK/100 cycles
      wr(REG_REPLAY, 32'h0D);
      repeat (CLK / 100 - 10) @(posedge clock_i);
      chk("addr", buf_addr_o, 38);
      repeat (20) @(posedge clock_i);
      chk("addr", buf_addr_o, 39);
      $display("test timed replay done");
      wrap_up();
   end
endmodule : serial_link_exerciser_tb_top
